//--- dca_arbiter.sv
// dca_arbiter: item buffer and the two-level channel arbiter with burst control
`timescale 1ns/1ps
`default_nettype none

module dca_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic avail;
  } dca_fifo_st_t;
  dca_fifo_st_t s_q, s_d;
  logic push, pop;

  assign push = in_valid_i && !s_q.full;
  assign pop = out_ready_i && s_q.avail;
  assign in_ready_o = !s_q.full;
  // valid is a flop of its own so the output needs no gate and resets to zero
  assign out_valid_o = s_q.avail;
  assign out_data_o = s_q.mem[s_q.rp];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wp] = in_data_i;
      s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + AW'(1);
    end
    if (pop) begin
      s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + AW'(1);
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    s_d.full = (s_d.cnt == (AW+1)'(DEPTH));
    s_d.avail = (s_d.cnt != '0);
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule // dca_fifo

module dca_arbiter (
  input wire logic clk_i,
  input wire logic resetn_i,
  dca_link_if.dev link,
  input wire logic [dca_pkg::NCH-1:0] prio_set_i,
  input wire logic [dca_pkg::NCH-1:0] prio_clr_i,
  input wire logic [dca_pkg::NCH-1:0] burst_only_set_i,
  input wire logic [dca_pkg::NCH-1:0] burst_only_clr_i,
  input wire logic [dca_pkg::NCH-1:0] enable_set_i,
  input wire logic [dca_pkg::NCH-1:0] enable_clr_i,
  input wire logic [dca_pkg::NCH-1:0] req_mask_i,
  input wire logic [dca_pkg::NCH-1:0] sw_req_i,
  input wire logic cfg_we_i,
  input wire logic [dca_pkg::CHW-1:0] cfg_chan_i,
  input wire logic [dca_pkg::CNT_W-1:0] cfg_count_i,
  input wire logic [dca_pkg::ALOG_W-1:0] cfg_arb_log2_i,
  input wire logic [1:0] cfg_size_i,
  input wire logic [1:0] cfg_sinc_i,
  input wire logic [1:0] cfg_dinc_i,
  input wire logic [dca_pkg::DW-1:0] cfg_saddr_i,
  input wire logic [dca_pkg::DW-1:0] cfg_daddr_i,
  output logic item_valid_o,
  input wire logic item_ready_i,
  output logic [$bits(dca_pkg::dca_item_t)-1:0] item_o,
  output logic [dca_pkg::NCH-1:0] enable_o,
  output logic [dca_pkg::NCH-1:0] prio_o,
  output logic busy_o,
  output logic [dca_pkg::CHW-1:0] grant_chan_o
);
  localparam int NCH = dca_pkg::NCH;
  localparam int CHW = dca_pkg::CHW;
  localparam int CNT_W = dca_pkg::CNT_W;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [NCH-1:0] prio;
    logic [NCH-1:0] burst_only;
    logic [NCH-1:0] enable;
    logic [NCH-1:0] sw_pend;
    logic [NCH-1:0][CNT_W-1:0] remain;
    logic [NCH-1:0][dca_pkg::ALOG_W-1:0] arb_log2;
    logic [NCH-1:0][1:0] size;
    logic [NCH-1:0][1:0] sinc;
    logic [NCH-1:0][1:0] dinc;
    logic [NCH-1:0][dca_pkg::DW-1:0] saddr;
    logic [NCH-1:0][dca_pkg::DW-1:0] daddr;
    dca_pkg::dca_state_t st;
    logic [CHW-1:0] chan;
    logic [CNT_W-1:0] burst_left;
    logic busy;
    logic ack;
    logic [NCH-1:0] done;
  } dca_arb_st_t;
  dca_arb_st_t s_q, s_d;

  // lowest set index wins; bit CHW flags that anything was set
  function automatic logic [CHW:0] pick(input logic [NCH-1:0] v);
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (v[i]) begin
        pick = {1'b1, CHW'(i)};
      end
    end
  endfunction

  logic [NCH-1:0] elig, burst_sel;
  logic [CHW:0] win_hi, win_lo, win;
  logic [CNT_W-1:0] blen;
  logic fifo_ready, move;
  dca_pkg::dca_item_t item;

  // sw requests act as bursts; burst wins over single when both are up
  assign burst_sel = link.breq | s_q.sw_pend;
  assign elig = s_q.enable & ((~req_mask_i & (link.breq | (link.sreq & ~s_q.burst_only)))
                | s_q.sw_pend);
  assign win_hi = pick(elig & s_q.prio);
  assign win_lo = pick(elig);
  assign win = win_hi[CHW] ? win_hi : win_lo;
  // a core bus cycle holds the move even mid-burst
  assign move = (s_q.st == dca_pkg::ST_MOVE) && !link.core_busy && fifo_ready;

  always_comb begin
    item.chan = s_q.chan;
    item.size = s_q.size[s_q.chan];
    item.saddr = s_q.saddr[s_q.chan];
    item.daddr = s_q.daddr[s_q.chan];
    item.data = link.pdata;
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.done = '0;
    blen = CNT_W'(1) << s_q.arb_log2[win[CHW-1:0]];
    s_d.prio = (s_q.prio & ~prio_clr_i) | prio_set_i;
    s_d.burst_only = (s_q.burst_only & ~burst_only_clr_i) | burst_only_set_i;
    s_d.sw_pend = s_q.sw_pend | (sw_req_i & s_q.enable);
    s_d.enable = (s_q.enable & ~enable_clr_i) | enable_set_i;
    if (cfg_we_i) begin
      // every channel keeps its own copy of the loaded structure
      s_d.remain[cfg_chan_i] = cfg_count_i;
      s_d.arb_log2[cfg_chan_i] = (cfg_arb_log2_i > dca_pkg::ALOG_MAX) ? dca_pkg::ALOG_MAX
                                 : cfg_arb_log2_i;
      s_d.size[cfg_chan_i] = cfg_size_i;
      s_d.sinc[cfg_chan_i] = cfg_sinc_i;
      s_d.dinc[cfg_chan_i] = cfg_dinc_i;
      s_d.saddr[cfg_chan_i] = cfg_saddr_i;
      s_d.daddr[cfg_chan_i] = cfg_daddr_i;
    end
    unique case (s_q.st)
      dca_pkg::ST_IDLE: begin
        if (win[CHW]) begin
          s_d.chan = win[CHW-1:0];
          s_d.busy = 1'b1;
          s_d.st = dca_pkg::ST_MOVE;
          if (burst_sel[win[CHW-1:0]]) begin
            s_d.burst_left = (blen < s_q.remain[win[CHW-1:0]]) ? blen
                             : s_q.remain[win[CHW-1:0]];
          end else begin
            s_d.burst_left = dca_pkg::CNT_ONE;
          end
        end
      end
      dca_pkg::ST_MOVE: begin
        if (move) begin
          s_d.ack = 1'b1;
          s_d.remain[s_q.chan] = s_q.remain[s_q.chan] - dca_pkg::CNT_ONE;
          s_d.burst_left = s_q.burst_left - dca_pkg::CNT_ONE;
          s_d.saddr[s_q.chan] = s_q.saddr[s_q.chan] + dca_pkg::inc_amount(s_q.sinc[s_q.chan]);
          s_d.daddr[s_q.chan] = s_q.daddr[s_q.chan] + dca_pkg::inc_amount(s_q.dinc[s_q.chan]);
          if (s_q.remain[s_q.chan] == dca_pkg::CNT_ONE) begin
            s_d.done[s_q.chan] = 1'b1;
            s_d.enable[s_q.chan] = enable_set_i[s_q.chan];
            s_d.sw_pend[s_q.chan] = sw_req_i[s_q.chan];
            s_d.st = dca_pkg::ST_WAIT;
          end else if (s_q.burst_left == dca_pkg::CNT_ONE) begin
            s_d.st = dca_pkg::ST_WAIT;
          end
        end
      end
      dca_pkg::ST_WAIT: begin
        // one spare cycle lets the peripheral retire the acknowledged items
        s_d.busy = 1'b0;
        s_d.st = dca_pkg::ST_IDLE;
      end
      default: begin
        s_d.st = dca_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // item buffer
  // ---------------------------------------------------------------
  dca_fifo #(
    .W($bits(dca_pkg::dca_item_t)),
    .DEPTH(dca_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(move),
    .in_ready_o(fifo_ready),
    .in_data_i(item),
    .out_valid_o(item_valid_o),
    .out_ready_i(item_ready_i),
    .out_data_o(item_o)
  );

  assign link.ack = s_q.ack;
  assign link.ack_chan = s_q.chan;
  assign link.done = s_q.done;
  assign enable_o = s_q.enable;
  assign prio_o = s_q.prio;
  assign busy_o = s_q.busy;
  assign grant_chan_o = s_q.chan;
endmodule // dca_arbiter
`default_nettype wire

//--- dca_pkg.sv
// dca_pkg: shared constants and types for the channel arbiter and its request-side partner
`default_nettype none
package dca_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NCH = 32;
  localparam int CHW = 5;
  localparam int DW = 32;
  localparam int CNT_W = 11;
  localparam int ALOG_W = 4;
  localparam int LVL_W = 4;
  localparam int FIFO_DEPTH = 32;
  localparam logic [ALOG_W-1:0] ALOG_MAX = 4'hA;
  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [LVL_W-1:0] LVL_ONE = 4'h1;
  localparam logic [LVL_W-1:0] SSI_BURST_LVL = 4'h4;

  // ---------------------------------------------------------------
  // channel map
  // ---------------------------------------------------------------
  localparam logic [CHW-1:0] CH_USB_FIRST = 5'h00;
  localparam logic [CHW-1:0] CH_USB_LAST = 5'h05;
  localparam logic [CHW-1:0] CH_UART_RX = 5'h08;
  localparam logic [CHW-1:0] CH_UART_TX = 5'h09;
  localparam logic [CHW-1:0] CH_FIRST_SYNC_SERIAL_PORT_RX = 5'h0A;
  localparam logic [CHW-1:0] CH_FIRST_SYNC_SERIAL_PORT_TX = 5'h0B;
  localparam logic [CHW-1:0] CH_SECOND_SYNC_SERIAL_PORT_RX = 5'h18;
  localparam logic [CHW-1:0] CH_SECOND_SYNC_SERIAL_PORT_TX = 5'h19;
  localparam logic [CHW-1:0] CH_SW = 5'h1E;

  // ---------------------------------------------------------------
  // item size and address increment codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] INC_BYTE = 2'h0;
  localparam logic [1:0] INC_HALF = 2'h1;
  localparam logic [1:0] INC_WORD = 2'h2;
  localparam logic [1:0] INC_NONE = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_WAIT} dca_state_t;

  typedef struct packed {
    logic [CHW-1:0] chan;
    logic [1:0] size;
    logic [DW-1:0] saddr;
    logic [DW-1:0] daddr;
    logic [DW-1:0] data;
  } dca_item_t;

  function automatic logic [DW-1:0] inc_amount(input logic [1:0] inc);
    unique case (inc)
      INC_BYTE: inc_amount = 32'h0000_0001;
      INC_HALF: inc_amount = 32'h0000_0002;
      INC_WORD: inc_amount = 32'h0000_0004;
      default: inc_amount = 32'h0000_0000;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- dca_link_if.sv
// dca_link_if: request, acknowledge and completion lines between arbiter and peripherals
`timescale 1ns/1ps
`default_nettype none
interface dca_link_if;
  logic [dca_pkg::NCH-1:0] sreq;
  logic [dca_pkg::NCH-1:0] breq;
  logic [dca_pkg::DW-1:0] pdata;
  logic core_busy;
  logic ack;
  logic [dca_pkg::CHW-1:0] ack_chan;
  logic [dca_pkg::NCH-1:0] done;

  modport dev (input sreq, breq, pdata, core_busy, output ack, ack_chan, done);
  modport per (output sreq, breq, pdata, core_busy, input ack, ack_chan, done);
endinterface
`default_nettype wire

//--- dca_periph.sv
// dca_periph: peripheral-side request generator and core bus-use indicator
`timescale 1ns/1ps
`default_nettype none
module dca_periph (
  input wire logic clk_i,
  input wire logic resetn_i,
  dca_link_if.per link,
  input wire logic lvl_load_i,
  input wire logic [dca_pkg::CHW-1:0] lvl_chan_i,
  input wire logic [dca_pkg::LVL_W-1:0] lvl_value_i,
  input wire logic [dca_pkg::LVL_W-1:0] uart_burst_lvl_i,
  input wire logic [dca_pkg::DW-1:0] data_i,
  input wire logic core_req_i,
  output logic got_item_o,
  output logic [dca_pkg::CHW-1:0] got_chan_o,
  output logic [dca_pkg::NCH-1:0] done_o
);
  localparam int NCH = dca_pkg::NCH;
  localparam int LVL_W = dca_pkg::LVL_W;

  typedef struct packed {
    logic [NCH-1:0][LVL_W-1:0] level;
    logic [NCH-1:0] sreq;
    logic [NCH-1:0] breq;
    logic [dca_pkg::DW-1:0] pdata;
    logic core_busy;
    logic got;
    logic [dca_pkg::CHW-1:0] got_chan;
    logic [NCH-1:0] done;
  } dca_per_st_t;
  dca_per_st_t s_q, s_d;

  function automatic logic is_ssi(input logic [dca_pkg::CHW-1:0] c);
    is_ssi = (c == dca_pkg::CH_FIRST_SYNC_SERIAL_PORT_RX) || (c == dca_pkg::CH_FIRST_SYNC_SERIAL_PORT_TX) ||
             (c == dca_pkg::CH_SECOND_SYNC_SERIAL_PORT_RX) || (c == dca_pkg::CH_SECOND_SYNC_SERIAL_PORT_TX);
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.got = link.ack;
    s_d.got_chan = link.ack_chan;
    s_d.done = link.done;
    s_d.pdata = data_i;
    s_d.core_busy = core_req_i;
    if (link.ack && s_q.level[link.ack_chan] != '0) begin
      s_d.level[link.ack_chan] = s_q.level[link.ack_chan] - dca_pkg::LVL_ONE;
    end
    if (lvl_load_i) begin
      s_d.level[lvl_chan_i] = lvl_value_i;
    end
    for (int i = 0; i < NCH; i++) begin
      s_d.sreq[i] = 1'b0;
      s_d.breq[i] = 1'b0;
      // requests follow the level after this cycle's acknowledge
      if (dca_pkg::CHW'(i) <= dca_pkg::CH_USB_LAST) begin
        s_d.breq[i] = (s_d.level[i] != '0);
      end else if (dca_pkg::CHW'(i) == dca_pkg::CH_UART_RX ||
                   dca_pkg::CHW'(i) == dca_pkg::CH_UART_TX) begin
        s_d.sreq[i] = (s_d.level[i] != '0);
        s_d.breq[i] = (uart_burst_lvl_i != '0) && (s_d.level[i] >= uart_burst_lvl_i);
      end else if (is_ssi(dca_pkg::CHW'(i))) begin
        s_d.sreq[i] = (s_d.level[i] != '0);
        s_d.breq[i] = (s_d.level[i] >= dca_pkg::SSI_BURST_LVL);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sreq = s_q.sreq;
  assign link.breq = s_q.breq;
  assign link.pdata = s_q.pdata;
  assign link.core_busy = s_q.core_busy;
  assign got_item_o = s_q.got;
  assign got_chan_o = s_q.got_chan;
  assign done_o = s_q.done;
endmodule // dca_periph
`default_nettype wire

//--- dca_link_sva.sv
// dca_link_sva: concurrent checks on the request and acknowledge link
`timescale 1ns/1ps
`default_nettype none
module dca_link_sva (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [dca_pkg::NCH-1:0] sreq,
  input wire logic [dca_pkg::NCH-1:0] breq,
  input wire logic core_busy,
  input wire logic ack,
  input wire logic [dca_pkg::CHW-1:0] ack_chan,
  input wire logic [dca_pkg::NCH-1:0] done
);
  // channels with no peripheral behind them
  localparam logic [31:0] UNMAPPED = 32'hFCFF_F0C0;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // -------------------------------------------------------------
  // bus yield and completion
  // -------------------------------------------------------------
  a_core_stall: assert property (core_busy |=> !ack)
    else $error("item moved while core held the bus");
  a_stall_run: assert property (core_busy [*2] |-> !ack ##1 !ack)
    else $error("item moved during a long core hold");
  a_done_pulse: assert property (|done |=> done == '0)
    else $error("completion line held over one cycle");
  a_done_onehot: assert property ($onehot0(done))
    else $error("two completion lines at once");
  a_done_granted: assert property (|done |-> done[ack_chan])
    else $error("completion on a channel that was not served");
  a_burst_steady: assert property (ack && $past(ack) |-> $stable(ack_chan))
    else $error("channel changed inside a burst");
  // -------------------------------------------------------------
  // request sources
  // -------------------------------------------------------------
  a_usb_no_single: assert property (sreq[5:0] == 6'h00)
    else $error("endpoint channel raised a single request");
  a_unmapped_quiet: assert property (((sreq | breq) & UNMAPPED) == '0)
    else $error("request on a channel with no peripheral");
  a_ssi_burst_sub: assert property ((breq & ~sreq & 32'h0300_0C00) == '0)
    else $error("serial port burst without single request");
  a_uart_burst_sub: assert property ((breq[9:8] & ~sreq[9:8]) == 2'h0)
    else $error("async port burst without single request");
endmodule // dca_link_sva
`default_nettype wire

//--- tb.sv
// tb: directed tests for the channel arbiter and its peripheral side
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [31:0] DATA = 32'hC3A5_5A3C;
  logic clk_i, resetn_i, cfg_we, item_ready, item_valid, busy, lvl_load, core_req, got_item;
  logic [6:0][31:0] pv;
  logic [31:0] req_mask, cfg_saddr, cfg_daddr, enable_v, prio_v, done_v;
  logic [4:0] cfg_chan, lvl_chan, got_chan, grant;
  logic [10:0] cfg_count;
  logic [3:0] cfg_lg, lvl_value, uart_thr;
  logic [1:0] cfg_size, cfg_sinc, cfg_dinc;
  logic [$bits(dca_pkg::dca_item_t)-1:0] item;
  int n_errors, checks;
  int n_got [32];
  int n_done [32];
  logic [4:0] gotq [$];
  dca_link_if link ();
  dca_arbiter dca_arbiter_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
    .prio_set_i(pv[0]), .prio_clr_i(pv[1]), .burst_only_set_i(pv[2]), .burst_only_clr_i(pv[3]),
    .enable_set_i(pv[4]), .enable_clr_i(pv[5]), .req_mask_i(req_mask), .sw_req_i(pv[6]),
    .cfg_we_i(cfg_we), .cfg_chan_i(cfg_chan), .cfg_count_i(cfg_count), .cfg_arb_log2_i(cfg_lg),
    .cfg_size_i(cfg_size), .cfg_sinc_i(cfg_sinc), .cfg_dinc_i(cfg_dinc), .cfg_saddr_i(cfg_saddr),
    .cfg_daddr_i(cfg_daddr), .item_valid_o(item_valid), .item_ready_i(item_ready),
    .item_o(item), .enable_o(enable_v), .prio_o(prio_v), .busy_o(busy), .grant_chan_o(grant));
  dca_periph dca_periph_inst (.clk_i(clk_i), .resetn_i(resetn_i), .link(link),
    .lvl_load_i(lvl_load), .lvl_chan_i(lvl_chan), .lvl_value_i(lvl_value),
    .uart_burst_lvl_i(uart_thr), .data_i(DATA), .core_req_i(core_req),
    .got_item_o(got_item), .got_chan_o(got_chan), .done_o(done_v));
  dca_link_sva dca_link_sva_inst (.clk_i(clk_i), .resetn_i(resetn_i), .sreq(link.sreq),
    .breq(link.breq), .core_busy(link.core_busy), .ack(link.ack), .ack_chan(link.ack_chan),
    .done(link.done));
  // -------------------------------------------------------------
  // clock, monitor and helpers
  // -------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (got_item === 1'b1) begin
      n_got[got_chan]++;
      gotq.push_back(got_chan);
    end
    for (int c = 0; c < 32; c++) if (done_v[c] === 1'b1) n_done[c]++;
  end
  task automatic tick();
    @(posedge clk_i);
    #5;
  endtask
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pulse(input int k, input logic [31:0] m, input int k2 = -1);
    logic [6:0][31:0] v;
    v = '0;
    v[k] = m;
    if (k2 >= 0) v[k2] = m;
    pv = v;
    tick();
    pv = '0;
    // an idle edge keeps a following pulse from rewriting pv in this time step
    tick();
  endtask
  // configure then enable; never called while that channel is moving
  task automatic setup(input logic [4:0] ch, input logic [10:0] n, input logic [3:0] lg,
                       input logic [1:0] sz, si, di, input logic [31:0] sa, da);
    {cfg_chan, cfg_count, cfg_lg, cfg_size, cfg_sinc, cfg_dinc} = {ch, n, lg, sz, si, di};
    {cfg_saddr, cfg_daddr} = {sa, da};
    cfg_we = 1'b1;
    tick();
    cfg_we = 1'b0;
    pulse(4, 32'h1 << ch);
  endtask
  task automatic lvl(input logic [4:0] ch, input logic [3:0] v);
    {lvl_load, lvl_chan, lvl_value} = {1'b1, ch, v};
    tick();
    lvl_load = 1'b0;
    tick();
  endtask
  // busy may dip between single items, so demand eight quiet cycles
  task automatic settle();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 8; i++) begin
      tick();
      q = (busy === 1'b0) ? q + 1 : 0;
    end
    chk(q, 8);
  endtask
  function automatic logic [31:0] incv(input logic [1:0] k);
    return (k == 2'h3) ? 32'h0 : 32'h1 << k;
  endfunction
  task automatic pop(input logic [4:0] ch, input logic [1:0] sz, si, di,
                     input logic [31:0] sa, da, input int n);
    dca_pkg::dca_item_t e;
    item_ready = 1'b1;
    for (int j = 0; j < n; j++) begin
      e = '{ch, sz, sa + 32'(j) * incv(si), da + 32'(j) * incv(di), DATA};
      chk({item_valid, item}, {1'b1, e});
      tick();
    end
    item_ready = 1'b0;
  endtask
  task automatic conclude();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    conclude();
  end
  // -------------------------------------------------------------
  // tests
  // -------------------------------------------------------------
  initial begin
    {resetn_i, cfg_we, item_ready, lvl_load, core_req, pv, req_mask} = '0;
    {cfg_chan, cfg_count, cfg_lg, cfg_size, cfg_sinc, cfg_dinc, cfg_saddr, cfg_daddr} = '0;
    {lvl_chan, lvl_value, uart_thr} = '0;
    repeat (6) @(posedge clk_i);
    #5 resetn_i = 1'b1;
    item_ready = 1'b1;
    tick();
    chk({enable_v, prio_v, busy, item_valid}, '0);
    pulse(0, 32'h0000_0080);
    chk(prio_v, 32'h0000_0080);
    pulse(1, 32'h0000_0080);
    chk(prio_v, 32'h0);
    pulse(0, 32'h0000_0100, 1);
    chk(prio_v, 32'h0000_0100);
    pulse(1, 32'h0000_0100);
    setup(5'h06, 11'h001, 4'h0, 2'h2, 2'h2, 2'h2, 32'h0, 32'h0);
    setup(5'h0C, 11'h001, 4'h0, 2'h2, 2'h2, 2'h2, 32'h0, 32'h0);
    setup(5'h1F, 11'h001, 4'h0, 2'h2, 2'h2, 2'h2, 32'h0, 32'h0);
    pulse(0, 32'h8000_0000);
    gotq.delete();
    pulse(6, 32'h8000_1040);
    settle();
    chk({gotq.size(), gotq[0], gotq[1], gotq[2]}, {32'd3, 5'h1F, 5'h06, 5'h0C});
    chk(n_done[6] + n_done[12] + n_done[31], 3);
    chk(enable_v & 32'h8000_1040, 32'h0);
    setup(5'h01, 11'h001, 4'h0, 2'h2, 2'h2, 2'h2, 32'h0, 32'h0);
    pulse(0, 32'h0000_0002);
    setup(5'h0D, 11'h004, 4'h2, 2'h2, 2'h2, 2'h2, 32'h0, 32'h0);
    gotq.delete();
    pulse(6, 32'h0000_2000);
    core_req = 1'b1;
    pulse(6, 32'h0000_0002);
    chk(grant, 5'h0D);
    repeat (3) tick();
    core_req = 1'b0;
    settle();
    chk({gotq.size(), gotq[0], gotq[3], gotq[4]}, {32'd5, 5'h0D, 5'h0D, 5'h01});
    setup(5'h08, 11'h003, 4'h2, 2'h0, 2'h3, 2'h0, 32'h0, 32'h0);
    lvl(5'h08, 4'h1);
    settle();
    chk({n_got[8], enable_v[8]}, {32'd1, 1'b1});
    setup(5'h0A, 11'h006, 4'h2, 2'h1, 2'h3, 2'h1, 32'h0, 32'h0);
    lvl(5'h0A, 4'h4);
    lvl(5'h0A, 4'h0);
    settle();
    chk(n_got[10], 4);
    lvl(5'h0A, 4'h5);
    settle();
    chk({n_got[10], n_done[10], enable_v[10]}, {32'd6, 32'd1, 1'b0});
    uart_thr = 4'h3;
    setup(5'h09, 11'h008, 4'h2, 2'h0, 2'h0, 2'h3, 32'h0, 32'h0);
    pulse(2, 32'h0000_0200);
    lvl(5'h09, 4'h2);
    settle();
    chk(n_got[9], 0);
    lvl(5'h09, 4'h3);
    settle();
    chk(n_got[9], 4);
    pulse(3, 32'h0000_0200);
    lvl(5'h09, 4'h1);
    settle();
    chk(n_got[9], 5);
    req_mask = 32'h0000_0800;
    setup(5'h0B, 11'h002, 4'h0, 2'h2, 2'h2, 2'h3, 32'h0, 32'h0);
    lvl(5'h0B, 4'h1);
    settle();
    chk(n_got[11], 0);
    req_mask = '0;
    settle();
    chk(n_got[11], 1);
    lvl(5'h18, 4'h1);
    setup(5'h19, 11'h002, 4'h0, 2'h2, 2'h2, 2'h3, 32'h0, 32'h0);
    pulse(5, 32'h0200_0000);
    pulse(6, 32'h0200_0000);
    settle();
    chk({n_got[24], n_got[25], enable_v[25]}, {32'd0, 32'd0, 1'b0});
    item_ready = 1'b0;
    for (int k = 0; k < 4; k++) begin
      setup(5'h1E, 11'h002, 4'h1, 2'(k % 3), 2'(k), 2'(3 - k), 32'h1000_0000 + 32'(k),
            32'h2000_0040);
      pulse(6, 32'h4000_0000);
      settle();
      pop(5'h1E, 2'(k % 3), 2'(k), 2'(3 - k), 32'h1000_0000 + 32'(k), 32'h2000_0040,
          2);
      chk(item_valid, 1'b0);
    end
    setup(5'h1F, 11'h028, 4'hA, 2'h2, 2'h2, 2'h3, 32'h3000_0000, 32'h4000_0000);
    pulse(6, 32'h8000_0000);
    for (int i = 0; i < 400 && n_got[31] < 33; i++) tick();
    repeat (10) tick();
    chk({n_got[31], item_valid}, {32'd33, 1'b1});
    pop(5'h1F, 2'h2, 2'h2, 2'h3, 32'h3000_0000, 32'h4000_0000, 2);
    tick();
    item_ready = 1'b1;
    settle();
    for (int i = 0; i < 100 && item_valid !== 1'b0; i++) tick();
    chk({n_got[31], n_done[31], item_valid}, {32'd41, 32'd2, 1'b0});
    conclude();
  end
endmodule // tb
`default_nettype wire
